// file: common/ctie_pkg.sv
// Constants for the capture/compare timer interrupt encoder.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package ctie_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [7:0] CTIE_IDX_ENABLE_MASK = 8'hc9;
	localparam logic [7:0] CTIE_IDX_PRIORITY_CODE = 8'hde;
	localparam logic [7:0] CTIE_IDX_SOURCE_FLAGS = 8'he9;
	localparam logic [7:0] CTIE_IDX_CTRL = 8'hf0;
	localparam logic [7:0] CTIE_IDX_EVT_STATUS = 8'hf1;
	localparam logic [7:0] CTIE_IDX_EVT_MASK = 8'hf2;
	// Flag and enable bit positions, shared by both registers.
	localparam int CTIE_BIT_CAP_A = 0;
	localparam int CTIE_BIT_CAP_B = 1;
	localparam int CTIE_BIT_RSVD = 2;
	localparam int CTIE_BIT_CMP_A = 3;
	localparam int CTIE_BIT_CMP_D = 6;
	localparam int CTIE_BIT_OVF = 7;
	localparam int CTIE_NUM_CMP = 4;
	// Control register fields.
	localparam int CTIE_BIT_GLOBAL_EN = 0;
	localparam int CTIE_BIT_GROUP_EN = 1;
	// Writable bits of the 8-bit registers; bit 2 is reserved.
	localparam logic [7:0] CTIE_SRC_WMASK = 8'hfb;
	localparam logic [7:0] CTIE_CTRL_WMASK = 8'h03;
	// Values after reset.
	localparam logic [7:0] CTIE_RST_FLAGS = 8'h00;
	localparam logic [7:0] CTIE_RST_ENABLE = 8'h00;
	localparam logic [7:0] CTIE_RST_CTRL = 8'h00;
	localparam logic [7:0] CTIE_RST_EVT = 8'h00;
	// Priority codes, lowest to highest.
	localparam logic [2:0] CTIE_CODE_NONE = 3'h0;
	localparam logic [2:0] CTIE_CODE_CMP_D = 3'h1;
	localparam logic [2:0] CTIE_CODE_CMP_C = 3'h2;
	localparam logic [2:0] CTIE_CODE_CMP_B = 3'h3;
	localparam logic [2:0] CTIE_CODE_CMP_A = 3'h4;
	localparam logic [2:0] CTIE_CODE_CAP_B = 3'h5;
	localparam logic [2:0] CTIE_CODE_CAP_A = 3'h6;
	localparam logic [2:0] CTIE_CODE_OVF = 3'h7;
endpackage

// file: rtl/ctie_top.sv
// Interrupt flags, enables and priority encoder of the timer unit.
// Assumes event inputs come from logic on clk_sys_i, one cycle pulses.
// Functional notes
// - Read-only 3-bit priority code sits in bits 2:0 of the code register.
// - Code reads 000 when no enabled source has its flag set.
// - Compare D gives 001, C 010, B 011, A 100; D is lowest.
// - Capture B gives 101, capture A 110, overflow 111 highest.
// - Writing 0 to a flag clears it; flags otherwise stay set.
// - Capture A event sets flag bit 0, capture B sets bit 1.
// - Timer equal to compare value sets bits 3..6 if channel enabled.
// - Timer overflow sets flag bit 7.
// - Compare request needs global, group and channel enable set.
// - Enable bits 0 and 1 gate captures together with global enable.
// - Enable bits 3..6 gate the compare channel requests.
// - Enable bit 7 gates the overflow request.
// - Flags are ANDed with enables before priority encoding.
// - All sources share one combined request to the processor.
module ctie_top
	import ctie_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic capture_a_evt_i,
	input wire logic capture_b_evt_i,
	input wire logic overflow_evt_i,
	input wire logic [15:0] unit_timer_value_i,
	input wire logic [15:0] compare_value_a_i,
	input wire logic [15:0] compare_value_b_i,
	input wire logic [15:0] compare_value_c_i,
	input wire logic [15:0] compare_value_d_i,
	input wire logic [3:0] compare_chan_en_i,
	output logic [2:0] priority_code_o,
	output logic cpu_irq_o,
	output logic irq_o
);

	logic [7:0] flags_reg;
	logic [7:0] flags_next;
	logic [7:0] enable_reg;
	logic [7:0] enable_next;
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic [7:0] evt_status_reg;
	logic [7:0] evt_status_next;
	logic [7:0] evt_mask_reg;
	logic [7:0] evt_mask_next;
	logic [3:0] match_prev_reg;
	logic [3:0] match_now;
	logic [3:0] match_rise;
	logic [15:0] cmp_val [CTIE_NUM_CMP];
	logic [7:0] set_vec;
	logic [7:0] masked;
	logic [2:0] code_comb;
	logic global_en;
	logic group_en;
	logic cap_req;
	logic grp_req;
	logic req_comb;
	logic [31:0] rd_data;
	logic [7:0] idx;
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic wr_lane;
	logic sel_flags;
	logic sel_enable;
	logic sel_code;
	logic sel_ctrl;
	logic sel_evt;
	logic sel_evt_mask;
	logic [31:0] dat_next;
	logic ack_next;

	// Gather the four compare values for the per-channel loop.
	assign cmp_val[0] = compare_value_a_i;
	assign cmp_val[1] = compare_value_b_i;
	assign cmp_val[2] = compare_value_c_i;
	assign cmp_val[3] = compare_value_d_i;

	// Detect the start of a match so a held match cannot refill a flag.
	genvar gi;
	generate
		for (gi = 0; gi < CTIE_NUM_CMP; gi++) begin : g_cmp
			assign match_now[gi] = compare_chan_en_i[gi] &&
				(unit_timer_value_i == cmp_val[gi]);
			assign match_rise[gi] = match_now[gi] && !match_prev_reg[gi];
		end
	endgenerate

	// Hardware set events in flag layout; bit 2 is never set.
	assign set_vec[CTIE_BIT_CAP_A] = capture_a_evt_i;
	assign set_vec[CTIE_BIT_CAP_B] = capture_b_evt_i;
	assign set_vec[CTIE_BIT_RSVD] = 1'b0;
	assign set_vec[CTIE_BIT_CMP_D:CTIE_BIT_CMP_A] = match_rise;
	assign set_vec[CTIE_BIT_OVF] = overflow_evt_i;

	// Bus decode; a request is served in the cycle its ack is high.
	assign idx = wb_adr_i[9:2];
	assign acc = wb_cyc_i && wb_stb_i && wb_ack_o;
	assign wr_acc = acc && wb_we_i;
	assign rd_acc = acc && !wb_we_i;
	assign wr_lane = wr_acc && wb_sel_i[0];
	assign sel_flags = (idx == CTIE_IDX_SOURCE_FLAGS);
	assign sel_enable = (idx == CTIE_IDX_ENABLE_MASK);
	assign sel_code = (idx == CTIE_IDX_PRIORITY_CODE);
	assign sel_ctrl = (idx == CTIE_IDX_CTRL);
	assign sel_evt = (idx == CTIE_IDX_EVT_STATUS);
	assign sel_evt_mask = (idx == CTIE_IDX_EVT_MASK);

	// Flags: a written 0 clears, a written 1 does nothing, set wins.
	assign flags_next = (wr_lane && sel_flags) ?
		(((flags_reg & wb_dat_i[7:0]) | set_vec) & CTIE_SRC_WMASK) :
		((flags_reg | set_vec) & CTIE_SRC_WMASK);

	// Enables and control; reserved bits are held at zero.
	assign enable_next = (wr_lane && sel_enable) ?
		(wb_dat_i[7:0] & CTIE_SRC_WMASK) : enable_reg;
	assign ctrl_next = (wr_lane && sel_ctrl) ?
		(wb_dat_i[7:0] & CTIE_CTRL_WMASK) : ctrl_reg;
	assign evt_mask_next = (wr_lane && sel_evt_mask) ?
		(wb_dat_i[7:0] & CTIE_SRC_WMASK) : evt_mask_reg;

	// Event status is cleared by a read, but a new event still lands.
	assign evt_status_next = ((rd_acc && sel_evt) ?
		set_vec : (evt_status_reg | set_vec)) & CTIE_SRC_WMASK;

	// Mask each flag with its enable before encoding.
	assign masked = flags_reg & enable_reg;

	// Fixed-priority encoder, overflow first and compare D last.
	assign code_comb =
		masked[CTIE_BIT_OVF] ? CTIE_CODE_OVF :
		masked[CTIE_BIT_CAP_A] ? CTIE_CODE_CAP_A :
		masked[CTIE_BIT_CAP_B] ? CTIE_CODE_CAP_B :
		masked[CTIE_BIT_CMP_A] ? CTIE_CODE_CMP_A :
		masked[CTIE_BIT_CMP_A+1] ? CTIE_CODE_CMP_B :
		masked[CTIE_BIT_CMP_A+2] ? CTIE_CODE_CMP_C :
		masked[CTIE_BIT_CMP_D] ? CTIE_CODE_CMP_D :
		CTIE_CODE_NONE;

	// One combined request: captures need only the global enable.
	assign global_en = ctrl_reg[CTIE_BIT_GLOBAL_EN];
	assign group_en = ctrl_reg[CTIE_BIT_GROUP_EN];
	assign cap_req = global_en && (|masked[CTIE_BIT_CAP_B:CTIE_BIT_CAP_A]);
	assign grp_req = global_en && group_en &&
		(|masked[CTIE_BIT_OVF:CTIE_BIT_CMP_A]);
	assign req_comb = cap_req || grp_req;

	// Read mux; the code is live so a read after a clear sees the next.
	assign rd_data =
		sel_flags ? {24'h000000, flags_reg} :
		sel_enable ? {24'h000000, enable_reg} :
		sel_code ? {29'h00000000, code_comb} :
		sel_ctrl ? {24'h000000, ctrl_reg} :
		sel_evt ? {24'h000000, evt_status_reg} :
		sel_evt_mask ? {24'h000000, evt_mask_reg} :
		32'h00000000;

	// Ack rises one cycle after the request and drops after one cycle.
	assign ack_next = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign dat_next = ack_next ? rd_data : 32'h00000000;

	// Bus answer registers.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else if (ce_i) begin
			wb_ack_o <= ack_next;
			wb_dat_o <= dat_next;
		end
	end

	// Software visible state.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			flags_reg <= CTIE_RST_FLAGS;
			enable_reg <= CTIE_RST_ENABLE;
			ctrl_reg <= CTIE_RST_CTRL;
			evt_status_reg <= CTIE_RST_EVT;
			evt_mask_reg <= CTIE_RST_EVT;
			match_prev_reg <= 4'h0;
		end else if (ce_i) begin
			flags_reg <= flags_next;
			enable_reg <= enable_next;
			ctrl_reg <= ctrl_next;
			evt_status_reg <= evt_status_next;
			evt_mask_reg <= evt_mask_next;
			match_prev_reg <= match_now;
		end
	end

	// Registered outputs: code and request track the masked flags, irq_o the masked event status.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			priority_code_o <= CTIE_CODE_NONE;
			cpu_irq_o <= 1'b0;
			irq_o <= 1'b0;
		end else if (ce_i) begin
			priority_code_o <= code_comb;
			cpu_irq_o <= req_comb;
			irq_o <= |(evt_status_reg & evt_mask_reg);
		end
	end

	// Checks on the encoder and flag behaviour.
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_clear_a;
		ce_i && wr_lane && sel_flags && !wb_dat_i[CTIE_BIT_CAP_A] &&
			!capture_a_evt_i;
	endsequence

	sequence s_match_a;
		ce_i && compare_chan_en_i[0] && !match_prev_reg[0] &&
			(unit_timer_value_i == compare_value_a_i);
	endsequence

	sequence s_cmp_req;
		ce_i && global_en && group_en && masked[CTIE_BIT_CMP_A];
	endsequence

	AST_CODE_NONE: assert property (ce_i && masked == 8'h00 |=>
		priority_code_o == CTIE_CODE_NONE)
		else $error("code not zero with nothing pending");

	AST_CODE_OVF: assert property (ce_i && masked[CTIE_BIT_OVF] |=>
		priority_code_o == CTIE_CODE_OVF)
		else $error("overflow not reported first");

	AST_CODE_CMP_D: assert property (ce_i && masked == 8'h40 |=>
		priority_code_o == CTIE_CODE_CMP_D)
		else $error("compare d code wrong");

	AST_CODE_CAP_B: assert property (ce_i && masked == 8'h0a |=>
		priority_code_o == CTIE_CODE_CAP_B)
		else $error("capture b not above compare a");

	AST_CAP_A_SET: assert property (ce_i && capture_a_evt_i |=>
		flags_reg[CTIE_BIT_CAP_A])
		else $error("capture a flag not set");

	AST_OVF_SET: assert property (ce_i && overflow_evt_i |=>
		flags_reg[CTIE_BIT_OVF])
		else $error("overflow flag not set");

	AST_CMP_A_SET: assert property (s_match_a |=>
		flags_reg[CTIE_BIT_CMP_A])
		else $error("compare a flag not set on match");

	AST_FLAG_CLEAR: assert property (s_clear_a |=>
		!flags_reg[CTIE_BIT_CAP_A])
		else $error("flag not cleared by written zero");

	AST_FLAG_HOLD: assert property (ce_i && flags_reg[CTIE_BIT_OVF] &&
		!(wr_lane && sel_flags && !wb_dat_i[CTIE_BIT_OVF]) |=>
		flags_reg[CTIE_BIT_OVF])
		else $error("flag dropped without a clear");

	AST_CMP_REQ: assert property (s_cmp_req |=> cpu_irq_o)
		else $error("compare request not raised");

	AST_CMP_NO_GROUP: assert property (ce_i && !group_en &&
		masked[1:0] == 2'b00 |=> !cpu_irq_o)
		else $error("request without group enable");

	AST_CAP_REQ: assert property (ce_i && global_en &&
		masked[CTIE_BIT_CAP_A] |=> cpu_irq_o)
		else $error("capture request not raised");

	AST_MASK_HIDES: assert property (ce_i && flags_reg == 8'h80 &&
		!enable_reg[CTIE_BIT_OVF] |=> priority_code_o == CTIE_CODE_NONE)
		else $error("disabled source reported");

	AST_RSVD_ZERO: assert property (!flags_reg[CTIE_BIT_RSVD] &&
		!enable_reg[CTIE_BIT_RSVD])
		else $error("reserved bit set");

	AST_ONE_REQ: assert property (ce_i && masked == 8'h00 |=>
		!cpu_irq_o ##1 (!cpu_irq_o || $past(masked != 8'h00)))
		else $error("request without pending source");

	AST_CAP_B_SET: assert property (ce_i && capture_b_evt_i |=>
		flags_reg[CTIE_BIT_CAP_B])
		else $error("capture b flag not set");

	AST_GLOBAL_OFF: assert property (ce_i && !global_en |=>
		!cpu_irq_o)
		else $error("request without global enable");

endmodule

// file: sim/ctie_evt_src.sv
// Event source model for the timer, capture and compare logic.
// Assumes the bench raises go_i for one cycle with a source bit number.
module ctie_evt_src (
	input wire logic clk_sys_i,
	input wire logic go_i,
	input wire logic [2:0] bit_i,
	output logic cap_a_o,
	output logic cap_b_o,
	output logic ovf_o,
	output logic [15:0] timer_o,
	output logic [15:0] cmp_a_o,
	output logic [15:0] cmp_b_o,
	output logic [15:0] cmp_c_o,
	output logic [15:0] cmp_d_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Compare values differ, so one timer value hits one channel only.
	assign cmp_a_o = 16'h0a83;
	assign cmp_b_o = 16'h0a84;
	assign cmp_c_o = 16'h0a85;
	assign cmp_d_o = 16'h0a86;
	// Events last one cycle; the timer leaves a match after one cycle.
	always_ff @(posedge clk_sys_i) begin
		cap_a_o <= go_i && bit_i == 3'h0;
		cap_b_o <= go_i && bit_i == 3'h1;
		ovf_o <= go_i && bit_i == 3'h7;
		timer_o <= (go_i && bit_i >= 3'h3 && bit_i <= 3'h6) ?
			{13'h0150, bit_i} : 16'h0000;
	end
endmodule

// file: sim/tb.sv
// Self-checking bench for the timer interrupt encoder.
// Assumes the event source model drives all event and timer inputs.
module tb;
	import ctie_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0, rst_n_i = 1'b0, cyc = 1'b0, we = 1'b0, go = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [31:0] dat = 32'h0, rd, wb_dat_o;
	logic [2:0] bsel = 3'h0, code_o;
	logic [3:0] chan_en = 4'hf;
	logic wb_ack_o, cpu_irq_o, irq_o, cap_a, cap_b, ovf;
	logic [15:0] tmr, ca, cb, cc, cd;
	logic [7:0] m, en;
	logic [31:0] seed = 32'hd8f3;
	int bad_count = 0, n_compared = 0;
	ctie_evt_src SRC (.clk_sys_i(clk_sys_i), .go_i(go), .bit_i(bsel),
		.cap_a_o(cap_a), .cap_b_o(cap_b), .ovf_o(ovf), .timer_o(tmr),
		.cmp_a_o(ca), .cmp_b_o(cb), .cmp_c_o(cc), .cmp_d_o(cd));
	ctie_top DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .capture_a_evt_i(cap_a),
		.capture_b_evt_i(cap_b), .overflow_evt_i(ovf),
		.unit_timer_value_i(tmr), .compare_value_a_i(ca),
		.compare_value_b_i(cb), .compare_value_c_i(cc),
		.compare_value_d_i(cd), .compare_chan_en_i(chan_en),
		.priority_code_o(code_o), .cpu_irq_o(cpu_irq_o), .irq_o(irq_o));
	// Clock of 5 ns period.
	initial begin
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	// Next value of the pseudo-random sequence.
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction
	// Highest pending source of a masked flag set, as a code.
	function automatic logic [2:0] exp_code(input logic [7:0] f);
		if (f[7]) return 3'h7;
		if (f[0]) return 3'h6;
		if (f[1]) return 3'h5;
		for (int i = 3; i <= 6; i++)
			if (f[i]) return 3'(7 - i);
		return 3'h0;
	endfunction
	// Flag bit that belongs to a code.
	function automatic int bit_of(input logic [2:0] c);
		return c == 3'h7 ? 7 : c == 3'h6 ? 0 : c == 3'h5 ? 1 : 7 - int'(c);
	endfunction
	// Prints the counts and the verdict, then stops.
	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Compares one value and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One classic bus cycle; waits for ack under a bound.
	task automatic wb(input logic w, input logic [7:0] idx,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		cyc <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		dat <= {24'h0, d};
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		rd = wb_dat_o;
		cyc <= 1'b0;
		if (n >= 40) begin
			bad_count++;
			finish_test();
		end
	endtask
	// Asks the source model for one event and lets it settle.
	task automatic fire(input int k);
		@(posedge clk_sys_i);
		go <= 1'b1;
		bsel <= 3'(k);
		@(posedge clk_sys_i);
		go <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
	endtask
	// Main sequence; software never writes 1 to the reserved bit 2.
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		wb(1'b0, CTIE_IDX_SOURCE_FLAGS, 8'h00);
		chk(rd, 32'h0);
		wb(1'b0, CTIE_IDX_PRIORITY_CODE, 8'h00);
		chk(rd, 32'h0);
		wb(1'b1, CTIE_IDX_ENABLE_MASK, 8'hfb);
		wb(1'b0, CTIE_IDX_ENABLE_MASK, 8'h00);
		chk(rd, 32'hfb);
		wb(1'b1, CTIE_IDX_CTRL, 8'h03);
		// Each source alone sets its flag and gives its code.
		for (int k = 0; k < 8; k++) begin
			if (k == 2) continue;
			fire(k);
			wb(1'b0, CTIE_IDX_SOURCE_FLAGS, 8'h00);
			chk(rd, 32'h1 << k);
			wb(1'b0, CTIE_IDX_PRIORITY_CODE, 8'h00);
			chk(rd, exp_code(8'h1 << k));
			chk(code_o, exp_code(8'h1 << k));
			chk(cpu_irq_o, 32'h1);
			wb(1'b1, CTIE_IDX_SOURCE_FLAGS, 8'h00);
			wb(1'b0, CTIE_IDX_SOURCE_FLAGS, 8'h00);
			chk(rd, 32'h0);
		end
		// Random flag and enable sets, serviced one source at a time.
		repeat (8) begin
			seed = lfsr(seed);
			m = seed[7:0] & 8'hfb;
			seed = lfsr(seed);
			en = seed[7:0] & 8'hfb;
			wb(1'b1, CTIE_IDX_ENABLE_MASK, en);
			for (int k = 0; k < 8; k++)
				if (m[k]) fire(k);
			for (int i = 0; i < 8; i++) begin
				wb(1'b0, CTIE_IDX_PRIORITY_CODE, 8'h00);
				chk(rd, exp_code(m & en));
				chk(code_o, exp_code(m & en));
				chk(cpu_irq_o, |(m & en));
				if ((m & en) == 8'h00) break;
				m[bit_of(exp_code(m & en))] = 1'b0;
				wb(1'b1, CTIE_IDX_SOURCE_FLAGS, m);
			end
			wb(1'b0, CTIE_IDX_SOURCE_FLAGS, 8'h00);
			chk(rd, m);
			wb(1'b1, CTIE_IDX_SOURCE_FLAGS, 8'h00);
		end
		// A disabled compare channel raises no flag.
		chan_en <= 4'he;
		fire(3);
		wb(1'b0, CTIE_IDX_SOURCE_FLAGS, 8'h00);
		chk(rd, 32'h0);
		// A compare request waits for the global and group enables.
		wb(1'b1, CTIE_IDX_ENABLE_MASK, 8'hfb);
		wb(1'b1, CTIE_IDX_CTRL, 8'h02);
		fire(4);
		chk(cpu_irq_o, 32'h0);
		wb(1'b1, CTIE_IDX_CTRL, 8'h01);
		wb(1'b0, CTIE_IDX_PRIORITY_CODE, 8'h00);
		chk(rd, exp_code(8'h10));
		chk(cpu_irq_o, 32'h0);
		wb(1'b1, CTIE_IDX_CTRL, 8'h03);
		wb(1'b0, CTIE_IDX_PRIORITY_CODE, 8'h00);
		chk(cpu_irq_o, 32'h1);
		wb(1'b1, CTIE_IDX_SOURCE_FLAGS, 8'h00);
		// Overflow waits for its own enable bit.
		wb(1'b1, CTIE_IDX_ENABLE_MASK, 8'h7b);
		fire(7);
		chk(code_o, 32'h0);
		chk(cpu_irq_o, 32'h0);
		wb(1'b1, CTIE_IDX_ENABLE_MASK, 8'hfb);
		wb(1'b0, CTIE_IDX_PRIORITY_CODE, 8'h00);
		chk(rd, exp_code(8'h80));
		chk(cpu_irq_o, 32'h1);
		wb(1'b1, CTIE_IDX_SOURCE_FLAGS, 8'h00);
		// A capture request needs the global enable only.
		wb(1'b1, CTIE_IDX_CTRL, 8'h01);
		fire(0);
		chk(cpu_irq_o, 32'h1);
		wb(1'b1, CTIE_IDX_SOURCE_FLAGS, 8'h00);
		// Event status holds every event so far; a read empties it.
		wb(1'b0, CTIE_IDX_EVT_STATUS, 8'h00);
		chk(rd, 32'hfb);
		wb(1'b1, CTIE_IDX_EVT_MASK, 8'h01);
		fire(1);
		chk(irq_o, 32'h0);
		fire(0);
		chk(irq_o, 32'h1);
		wb(1'b0, CTIE_IDX_EVT_STATUS, 8'h00);
		chk(rd, 32'h03);
		repeat (3) @(posedge clk_sys_i);
		chk(irq_o, 32'h0);
		wb(1'b0, 8'h10, 8'h00);
		chk(rd, 32'h0);
		finish_test();
	end
endmodule
